//--- rtl/crw_pkg.sv
// package for the cec reception width timing block
// assumes a 16-bit word-wide register port and a cec clock enable
package crw_pkg;
	localparam int unsigned CRW_LIM_W = 9;
	localparam logic [19:0] CRW_OFS_START_MAX = 20'hF0316;
	localparam logic [19:0] CRW_OFS_ZERO_MIN = 20'hF0318;
	localparam logic [19:0] CRW_OFS_ZERO_MAX = 20'hF031A;
	localparam logic [19:0] CRW_OFS_DATA_MAX = 20'hF0322;
	localparam logic [19:0] CRW_OFS_SAMPLE = 20'hF030E;
	localparam logic [8:0] CRW_LIM_RESET = 9'h000;
	localparam logic [15:0] CRW_RD_IDLE = 16'h0000;

	typedef struct packed {
		logic [8:0] start_max;
		logic [8:0] zero_min;
		logic [8:0] zero_max;
		logic [8:0] data_max;
		logic [8:0] sample;
	} crw_limits_s;

	typedef struct packed {
		logic start_err;
		logic zero_err;
		logic data_err;
	} crw_err_s;

	typedef enum logic [1:0] {
		CRW_IDLE = 2'b00,
		CRW_START = 2'b01,
		CRW_LOW = 2'b10,
		CRW_HIGH = 2'b11
	} crw_state_e;
endpackage

//--- rtl/crw_rx_width.sv
// reception width limits and pulse width checking for a cec receiver
// assumes cec_line is the raw bus level, cec_tick a one-cycle pulse per
// cec operating clock period, and whole-word register writes
`timescale 1ns/1ps
// Contract
// - 9-bit start bit maximum width limit
// - 9-bit logical-0 minimum low width limit
// - 9-bit logical-0 maximum low width limit
// - 9-bit data bit maximum width limit
// - limits change only while function disabled
// - reset clears all width limits
// - sample data bit at setting plus one
module crw_rx_width
	import crw_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [19:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic cec_function_enable,
	input wire logic cec_tick,
	input wire logic cec_line,
	output logic rx_bit_valid,
	output logic rx_bit_value,
	output crw_err_s rx_err
);
	crw_limits_s lim_q;
	logic line_m_q, line_s_q, line_p_q;
	crw_state_e state_q;
	logic [9:0] cnt_q;
	logic sampled_q;
	logic wr_ok;
	logic fall;
	logic [9:0] start_lim, zmin_lim, zmax_lim, data_lim, samp_lim;

	assign wr_ok = reg_wr && !cec_function_enable;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lim_q.start_max <= CRW_LIM_RESET;
			lim_q.zero_min <= CRW_LIM_RESET;
			lim_q.zero_max <= CRW_LIM_RESET;
			lim_q.data_max <= CRW_LIM_RESET;
			lim_q.sample <= CRW_LIM_RESET;
		end else if (wr_ok) begin
			if (reg_addr == CRW_OFS_START_MAX) begin
				lim_q.start_max <= reg_wdata[8:0];
			end else if (reg_addr == CRW_OFS_ZERO_MIN) begin
				lim_q.zero_min <= reg_wdata[8:0];
			end else if (reg_addr == CRW_OFS_ZERO_MAX) begin
				lim_q.zero_max <= reg_wdata[8:0];
			end else if (reg_addr == CRW_OFS_DATA_MAX) begin
				lim_q.data_max <= reg_wdata[8:0];
			end else if (reg_addr == CRW_OFS_SAMPLE) begin
				lim_q.sample <= reg_wdata[8:0];
			end
		end
	end

	// read mux, upper bits read as zero
	always_comb begin
		reg_rdata = CRW_RD_IDLE;
		if (reg_addr == CRW_OFS_START_MAX) begin
			reg_rdata = {7'h00, lim_q.start_max};
		end else if (reg_addr == CRW_OFS_ZERO_MIN) begin
			reg_rdata = {7'h00, lim_q.zero_min};
		end else if (reg_addr == CRW_OFS_ZERO_MAX) begin
			reg_rdata = {7'h00, lim_q.zero_max};
		end else if (reg_addr == CRW_OFS_DATA_MAX) begin
			reg_rdata = {7'h00, lim_q.data_max};
		end else if (reg_addr == CRW_OFS_SAMPLE) begin
			reg_rdata = {7'h00, lim_q.sample};
		end
	end

	// line synchroniser
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_m_q <= 1'b1;
			line_s_q <= 1'b1;
			line_p_q <= 1'b1;
		end else begin
			line_m_q <= cec_line;
			line_s_q <= line_m_q;
			line_p_q <= line_s_q;
		end
	end

	assign fall = line_p_q && !line_s_q;
	// widths counted in cec periods, limit value plus one
	assign start_lim = {1'b0, lim_q.start_max} + 10'h001;
	assign zmin_lim = {1'b0, lim_q.zero_min} + 10'h001;
	assign zmax_lim = {1'b0, lim_q.zero_max} + 10'h001;
	assign data_lim = {1'b0, lim_q.data_max} + 10'h001;
	assign samp_lim = {1'b0, lim_q.sample} + 10'h001;

	// first falling edge after idle opens a start bit, later ones data bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= CRW_IDLE;
			cnt_q <= 10'h000;
		end else if (!cec_function_enable) begin
			state_q <= CRW_IDLE;
			cnt_q <= 10'h000;
		end else if (fall) begin
			state_q <= (state_q == CRW_IDLE) ? CRW_START : CRW_LOW;
			cnt_q <= 10'h000;
		end else begin
			case (state_q)
				CRW_IDLE: begin
					cnt_q <= 10'h000;
				end
				CRW_START: begin
					// start bit longer than limit aborts
					if (cec_tick && cnt_q >= start_lim) begin
						state_q <= CRW_IDLE;
					end else if (cec_tick) begin
						cnt_q <= cnt_q + 10'h001;
					end
				end
				CRW_LOW: begin
					if (line_s_q) begin
						state_q <= CRW_HIGH;
					end
					if (cec_tick && cnt_q != 10'h3FF) begin
						cnt_q <= cnt_q + 10'h001;
					end
				end
				CRW_HIGH: begin
					// data bit longer than limit ends frame
					if (cec_tick && cnt_q >= data_lim) begin
						state_q <= CRW_IDLE;
					end else if (cec_tick) begin
						cnt_q <= cnt_q + 10'h001;
					end
				end
				default: state_q <= CRW_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sampled_q <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_bit_value <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			if (fall) begin
				sampled_q <= 1'b0;
			end else if ((state_q == CRW_LOW || state_q == CRW_HIGH) &&
				!sampled_q && cec_tick && cnt_q + 10'h001 == samp_lim) begin
				sampled_q <= 1'b1;
				rx_bit_valid <= 1'b1;
				rx_bit_value <= line_s_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_err <= '0;
		end else begin
			rx_err <= '0;
			if (cec_function_enable) begin
				rx_err.start_err <= state_q == CRW_START && !fall &&
					cec_tick && cnt_q >= start_lim;
				rx_err.data_err <= state_q == CRW_HIGH && !fall &&
					cec_tick && cnt_q >= data_lim;
				// logical-0 low width check at rising edge
				rx_err.zero_err <= state_q == CRW_LOW && !fall &&
					line_s_q && sampled_q && !rx_bit_value &&
					(cnt_q < zmin_lim || cnt_q > zmax_lim);
			end
		end
	end

	a_limit_write_lock: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		cec_function_enable |=> $stable(lim_q))
		else $error("limit changed while enabled");

	a_limit_write_take: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(wr_ok && reg_addr == CRW_OFS_START_MAX) |=>
		lim_q.start_max == $past(reg_wdata[8:0]))
		else $error("start limit write lost");

	a_data_max_take: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(wr_ok && reg_addr == CRW_OFS_DATA_MAX) |=>
		lim_q.data_max == $past(reg_wdata[8:0]))
		else $error("data limit write lost");

	a_zero_min_take: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(wr_ok && reg_addr == CRW_OFS_ZERO_MIN) |=>
		lim_q.zero_min == $past(reg_wdata[8:0]))
		else $error("zero minimum write lost");

	a_zero_max_take: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(wr_ok && reg_addr == CRW_OFS_ZERO_MAX) |=>
		lim_q.zero_max == $past(reg_wdata[8:0]))
		else $error("zero maximum write lost");

	a_zero_err_cause: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rx_err.zero_err |-> $past(state_q) == CRW_LOW)
		else $error("zero error without low phase");

	a_sample_once: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rx_bit_valid |=> !rx_bit_valid)
		else $error("bit sampled twice");

	a_start_err_state: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rx_err.start_err |-> state_q == CRW_IDLE)
		else $error("start error did not abort");

	a_data_err_state: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rx_err.data_err |-> state_q == CRW_IDLE)
		else $error("data error did not end frame");

	a_reset_clears: assert property (
		@(posedge core_clk)
		$rose(rst_b) |-> lim_q == '0)
		else $error("limits not cleared by reset");
endmodule

//--- dv/crw_cec_peer.sv
// other cec device sharing the bus line, driven from the bench
// assumes a pull-up on the line and cec_tick as the time base
`timescale 1ns/1ps
module crw_cec_peer (
	input wire logic core_clk,
	input wire logic cec_tick,
	output wire logic cec_line
);
	logic drv_low = 1'b0;
	// released line is driven high directly, standing in for the pull-up
	assign cec_line = drv_low ? 1'b0 : 1'b1;
	task automatic hold(input logic low, input int n);
		int k;
		k = 0;
		@(negedge core_clk);
		drv_low = low;
		while (k < n) begin
			@(posedge core_clk);
			if (cec_tick)
				k++;
		end
	endtask
	task automatic send_bit(input int low, input int total);
		hold(1'b1, low);
		hold(1'b0, total - low);
	endtask
endmodule

//--- dv/test_crw_rx_width.sv
// bench for crw_rx_width: register model, write lock, line traffic
// assumes the peer model drives the pulled-up cec line
`timescale 1ns/1ps
module test_crw_rx_width;
	import crw_pkg::*;
	logic core_clk = 0, rst_b = 0, reg_wr = 0, cec_function_enable = 0;
	logic cec_tick = 0;
	logic [19:0] reg_addr = 20'h00000;
	logic [15:0] reg_wdata = 16'h0000;
	wire logic [15:0] reg_rdata;
	wire logic cec_line, rx_bit_valid, rx_bit_value;
	wire crw_err_s rx_err;
	int err_total = 0, checked = 0, seed = 22, n_zero = 0, n_start = 0;
	int n_data = 0;
	int mdl[6] = '{0, 0, 0, 0, 0, 0};
	logic [19:0] adr[6] = '{CRW_OFS_START_MAX, CRW_OFS_ZERO_MIN,
		CRW_OFS_ZERO_MAX, CRW_OFS_DATA_MAX, CRW_OFS_SAMPLE, 20'hF0320};
	logic exp_q[$];
	always #50 core_clk = ~core_clk;
	always @(negedge core_clk) cec_tick <= ~cec_tick;
	crw_rx_width uut (.core_clk(core_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .cec_function_enable(cec_function_enable),
		.cec_tick(cec_tick), .cec_line(cec_line),
		.rx_bit_valid(rx_bit_valid), .rx_bit_value(rx_bit_value),
		.rx_err(rx_err));
	crw_cec_peer peer (.core_clk(core_clk), .cec_tick(cec_tick),
		.cec_line(cec_line));
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input int i, input logic [15:0] d);
		@(negedge core_clk);
		reg_addr = adr[i];
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		if (!cec_function_enable)
			mdl[i] = int'(d[8:0]);
	endtask
	task automatic rd(input int i);
		@(negedge core_clk);
		reg_addr = adr[i];
		@(posedge core_clk);
		chk("reg_rdata", 16'(mdl[i]), reg_rdata);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// outputs are looked at mid-cycle, where they have settled
	always @(negedge core_clk) if (rst_b) begin
		if (rx_bit_valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("rx_bit_extra", 16'h0000, 16'h0001);
			else
				chk("rx_bit_value", 16'(exp_q.pop_front()),
					16'(rx_bit_value));
		end
		if (rx_err.zero_err === 1'b1)
			n_zero++;
		if (rx_err.start_err === 1'b1)
			n_start++;
		if (rx_err.data_err === 1'b1)
			n_data++;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) rst_b = 1'b1;
		for (int i = 0; i < 6; i++) rd(i);
		for (int r = 0; r < 2; r++) begin
			@(negedge core_clk) cec_function_enable = (r == 1);
			for (int i = 0; i < 5; i++) wr(i, 16'($random(seed)));
			for (int i = 0; i < 6; i++) rd(i);
		end
		@(negedge core_clk) cec_function_enable = 1'b0;
		wr(0, 16'h0028);
		wr(1, 16'h0008);
		wr(2, 16'h000F);
		wr(3, 16'h001E);
		wr(4, 16'h0006);
		@(negedge core_clk) cec_function_enable = 1'b1;
		exp_q = '{1'b0, 1'b1, 1'b0, 1'b0};
		peer.send_bit(20, 24);
		peer.send_bit(12, 16);
		peer.send_bit(3, 16);
		peer.send_bit(12, 16);
		peer.hold(1'b0, 60);
		peer.send_bit(20, 24);
		peer.send_bit(20, 24);
		peer.hold(1'b0, 60);
		peer.send_bit(60, 64);
		peer.hold(1'b0, 60);
		chk("zero_err count", 16'h0001, 16'(n_zero));
		chk("start_err count", 16'h0001, 16'(n_start));
		// each of the two frames that reach data bits ends in one overrun when left idle past the data limit
		chk("data_err count", 16'h0002, 16'(n_data));
		chk("bits left", 16'h0000, 16'(exp_q.size()));
		tally_and_finish;
	end
endmodule
